// [dv/cpu_model.sv]
// Behavioural model of the CPU software that drives the register port.
`timescale 1ns/1ns
`include "selfprog_cfg.svh"
module cpu_model (
    input wire logic clk,
    output logic [3:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [7:0] rdata
);
    // The bus starts idle at time zero.
    initial begin
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end

    // One write cycle; released lines show the inverse so stale data never looks valid.
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask

    // One read cycle; the data stand only in the cycle after the strobe.
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        v = rdata;
    endtask

    // Idle cycles, such as the no-op and halt after the final mode write.
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Full guarded mode change; the key and the three mode writes go back to back.
    task automatic unlock(input logic [7:0] key, input logic [7:0] v, input logic [7:0] inv,
                          output logic [7:0] st);
        wr_reg(`ADDR_FCMD, 8'h00);
        wr_reg(`ADDR_STATUS, 8'h00);
        // The write strobe stays high across all four writes.
        @(posedge clk);
        addr <= `ADDR_KEY;
        wdata <= key;
        wr <= 1'b1;
        @(posedge clk);
        addr <= `ADDR_MODE;
        wdata <= v;
        @(posedge clk);
        wdata <= inv;
        @(posedge clk);
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~`ADDR_MODE;
        wdata <= ~v;
        idle(3);
        rd_reg(`ADDR_STATUS, st);
    endtask
endmodule

// [dv/tb_top.sv]
// Self-checking testbench for the mode entry guard.
`timescale 1ns/1ns
`include "selfprog_cfg.svh"
module tb_top;
    import selfprog_pkg::*;
    logic clk; // Clock of 20 MHz, well above the 1 MHz floor.
    logic reset_n; // Synchronous reset, active low.
    logic [3:0] addr; // Register index from the CPU model.
    logic [7:0] wdata; // Write data from the CPU model.
    logic wr; // Write strobe.
    logic rd; // Read strobe.
    byte_t rdata_q; // Read data.
    logic self_prog_q; // Mode flag.
    logic [15:0] block_wen_q; // Per-block write enables.
    logic prot_bad_q; // Prohibited protect setting.
    logic irq_q; // Level interrupt.
    int error_cnt; // Mismatches seen.
    int checked; // Comparisons made.
    int cycles; // Cycles since time zero.
    logic [7:0] st; // Status read back by the CPU model.

    cpu_model u_cpu_model (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
                           .rdata(rdata_q));
    selfprog_guard u_selfprog_guard (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata_q(rdata_q), .self_prog_q(self_prog_q),
        .block_wen_q(block_wen_q), .prot_bad_q(prot_bad_q), .irq_q(irq_q));

    // The clock toggles every half period.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("Mismatches %0d of %0d comparisons", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Reads one register and compares it.
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        u_cpu_model.rd_reg(a, st);
        chk(16'(st), 16'(exp));
    endtask

    // A hang is cut short well beyond the expected run length.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt++;
            conclude();
        end
    end

    // Main sequence.
    initial begin
        reset_n = 1'b0;
        error_cnt = 0;
        checked = 0;
        cycles = 0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        // Reset values, a read of the key and an unmapped index.
        rchk(`ADDR_MODE, `MODE_NORMAL);
        rchk(`ADDR_STATUS, 8'h00);
        rchk(`ADDR_PROT, `PROT_RESET);
        rchk(`ADDR_KEY, 8'h00);
        rchk(4'h7, 8'h00);
        rchk(`ADDR_FCMD, 8'h00);
        chk(16'(prot_bad_q), 16'h0000);
        chk(16'(irq_q), 16'h0000);
        // Entry step by step, reading the mode between writes.
        u_cpu_model.wr_reg(`ADDR_IRQ_MASK, 8'h01);
        u_cpu_model.wr_reg(`ADDR_STATUS, 8'h00);
        u_cpu_model.wr_reg(`ADDR_KEY, `KEY_VALUE);
        u_cpu_model.wr_reg(`ADDR_MODE, `MODE_SELF);
        rchk(`ADDR_MODE, `MODE_NORMAL);
        u_cpu_model.wr_reg(`ADDR_MODE, 8'hfe);
        rchk(`ADDR_MODE, `MODE_NORMAL);
        u_cpu_model.wr_reg(`ADDR_MODE, `MODE_SELF);
        u_cpu_model.idle(3);
        chk(16'(self_prog_q), 16'h0001);
        rchk(`ADDR_MODE, `MODE_SELF);
        rchk(`ADDR_STATUS, 8'h00);
        chk(block_wen_q, 16'hffff);
        chk(16'(irq_q), 16'h0001);
        u_cpu_model.wr_reg(`ADDR_IRQ_STAT, 8'h01);
        u_cpu_model.idle(2);
        chk(16'(irq_q), 16'h0000);
        // A prohibited protect setting closes every block.
        u_cpu_model.wr_reg(`ADDR_PROT, 8'hfe);
        u_cpu_model.idle(2);
        chk(16'(prot_bad_q), 16'h0001);
        chk(block_wen_q, 16'h0000);
        u_cpu_model.wr_reg(`ADDR_PROT, `PROT_RESET);
        u_cpu_model.idle(2);
        chk(block_wen_q, 16'hffff);
        // The flash command register keeps what software wrote.
        u_cpu_model.wr_reg(`ADDR_FCMD, 8'h03);
        rchk(`ADDR_FCMD, 8'h03);
        // Wrong inverse, then a wrong key: both fail and leave the mode alone.
        u_cpu_model.wr_reg(`ADDR_IRQ_MASK, 8'h02);
        rchk(`ADDR_IRQ_MASK, 8'h02);
        for (int i = 0; i < 2; i++) begin
            u_cpu_model.unlock(i == 0 ? `KEY_VALUE : 8'h5a, `MODE_NORMAL,
                               i == 0 ? 8'h00 : 8'hff, st);
            chk(16'(st[`ERR_BIT]), 16'h0001);
            chk(16'(self_prog_q), 16'h0001);
            chk(16'(irq_q), 16'h0001);
            rchk(`ADDR_IRQ_STAT, 8'h02);
            u_cpu_model.wr_reg(`ADDR_IRQ_STAT, 8'h02);
        end
        // A stray write after the key breaks the sequence.
        u_cpu_model.wr_reg(`ADDR_STATUS, 8'h00);
        u_cpu_model.wr_reg(`ADDR_KEY, `KEY_VALUE);
        u_cpu_model.wr_reg(`ADDR_FCMD, 8'h00);
        u_cpu_model.idle(3);
        rchk(`ADDR_STATUS, 8'h01);
        u_cpu_model.wr_reg(`ADDR_IRQ_STAT, 8'h02);
        // Retry after clearing: return to normal mode succeeds.
        u_cpu_model.unlock(`KEY_VALUE, `MODE_NORMAL, 8'hff, st);
        chk(16'(st[`ERR_BIT]), 16'h0000);
        chk(16'(self_prog_q), 16'h0000);
        chk(block_wen_q, 16'h0000);
        chk(16'(irq_q), 16'h0000);
        rchk(`ADDR_FCMD, 8'h00);
        // Entry again with the four writes back to back.
        u_cpu_model.unlock(`KEY_VALUE, `MODE_SELF, 8'hfe, st);
        chk(16'(st[`ERR_BIT]), 16'h0000);
        chk(16'(self_prog_q), 16'h0001);
        rchk(`ADDR_MODE, `MODE_SELF);
        // A reset in mid-run returns the block to normal mode.
        u_cpu_model.idle(1);
        reset_n <= 1'b0;
        u_cpu_model.idle(2);
        reset_n <= 1'b1;
        chk(16'(self_prog_q), 16'h0000);
        chk(block_wen_q, 16'h0000);
        rchk(`ADDR_MODE, `MODE_NORMAL);
        rchk(`ADDR_PROT, `PROT_RESET);
        conclude();
    end
endmodule

// [rtl/irq_status.sv]
// Sticky event status with mask and level interrupt.
`timescale 1ns/1ns
module irq_status (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [1:0] events, // One-cycle event pulses.
    input wire logic clr_wr, // Write strobe to the status register.
    input wire logic [1:0] clr_bits, // Ones clear matching bits.
    input wire logic mask_wr, // Write strobe to the mask register.
    input wire logic [1:0] mask_bits,
    output logic [1:0] stat_q,
    output logic [1:0] mask_q,
    output logic irq_q // High while an unmasked bit is set.
);
    // Sticky bits; a new event wins over a clear in the same cycle.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            stat_q <= 2'h0;
        end else begin
            stat_q <= (stat_q & ~(clr_wr ? clr_bits : 2'h0)) | events;
        end
    end
    // Mask register, one enables the interrupt for that bit.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mask_q <= 2'h0;
        end else if (mask_wr) begin
            mask_q <= mask_bits;
        end
    end
    // Registered interrupt level.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(((stat_q & ~(clr_wr ? clr_bits : 2'h0)) | events) & mask_q);
        end
    end
endmodule

// [rtl/selfprog_cfg.svh]
// Constants for the self programming mode entry guard.
// What this block does
// - Key write must open every unlock sequence.
// - First target write only arms, not applied.
// - Second write must be inverse, not applied.
// - Third correct write applies the mode.
// - Error flag at status bit 0 reports failure.
// - All-ones protect byte leaves every block writable in self programming mode.
// - Return to normal uses same guarded pattern.
`ifndef SELFPROG_CFG_SVH
`define SELFPROG_CFG_SVH
`define ADDR_KEY 4'h0
`define ADDR_MODE 4'h1
`define ADDR_STATUS 4'h2
`define ADDR_FCMD 4'h3
`define ADDR_PROT 4'h4
`define ADDR_IRQ_STAT 4'h5
`define ADDR_IRQ_MASK 4'h6
`define KEY_VALUE 8'hA5
`define MODE_SELF 8'h01
`define MODE_NORMAL 8'h00
`define ERR_BIT 0
`define PROT_RESET 8'hFF
`define PROT_ALL_OPEN 4'hF
`define IRQ_BIT_OK 0
`define IRQ_BIT_ERR 1
`endif

// [rtl/selfprog_guard.sv]
// Top of the self programming mode entry guard with its register port.
`timescale 1ns/1ns
`include "selfprog_cfg.svh"
module selfprog_guard (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] addr, // Register index.
    input wire logic [7:0] wdata,
    input wire logic wr, // Write strobe.
    input wire logic rd, // Read strobe.
    output selfprog_pkg::byte_t rdata_q, // Read data, one cycle after rd.
    output logic self_prog_q, // High while in self programming mode.
    output logic [15:0] block_wen_q, // One per block allowed to write or erase.
    output logic prot_bad_q, // Protect byte holds a prohibited setting.
    output logic irq_q // Level interrupt.
);
    import selfprog_pkg::*;
    byte_t mode_q; // Mode control register, changed only by the guard.
    byte_t status_q; // Flash status register.
    byte_t fcmd_q; // Flash command register.
    byte_t prot_q; // Protect byte image.
    logic apply; // Guard accepted a third write.
    logic fail; // Guard saw a broken sequence.
    logic [1:0] irq_stat; // Sticky event bits.
    logic [1:0] irq_mask; // Event mask bits.
    logic wr_key; // Write to the key register.
    logic wr_mode; // Write to the mode register.
    logic wr_other; // Write elsewhere.
    byte_t wdata_d1_q; // Write data of the previous cycle.
    assign wr_key = wr && addr == `ADDR_KEY;
    assign wr_mode = wr && addr == `ADDR_MODE;
    assign wr_other = wr && !wr_key && !wr_mode;
    // Sequence checker.
    unlock_seq u_seq (
        .clk(clk),
        .reset_n(reset_n),
        .wr_key(wr_key),
        .wr_mode(wr_mode),
        .wr_other(wr_other),
        .wdata(wdata),
        .apply(apply),
        .fail(fail)
    );
    // Interrupt events: mode changed, sequence failed.
    irq_status u_irq (
        .clk(clk),
        .reset_n(reset_n),
        .events({fail, apply}),
        .clr_wr(wr && addr == `ADDR_IRQ_STAT),
        .clr_bits(wdata[1:0]),
        .mask_wr(wr && addr == `ADDR_IRQ_MASK),
        .mask_bits(wdata[1:0]),
        .stat_q(irq_stat),
        .mask_q(irq_mask),
        .irq_q(irq_q)
    );
    // Mode register takes only the value of a completed sequence.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mode_q <= `MODE_NORMAL;
        end else if (apply) begin
            mode_q <= wdata_d1_q;
        end
    end
    // Holds the data that produced the apply pulse.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wdata_d1_q <= 8'h00;
        end else begin
            wdata_d1_q <= wdata;
        end
    end
    // Mode output is high when an applied mode value equals MODE_SELF.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            self_prog_q <= 1'b0;
        end else if (apply) begin
            self_prog_q <= wdata_d1_q == `MODE_SELF;
        end
    end
    // Status: software writes it; a failed sequence sets the error bit, set wins.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            status_q <= 8'h00;
        end else begin
            if (wr && addr == `ADDR_STATUS) begin
                status_q <= wdata;
            end
            if (fail) begin
                status_q[`ERR_BIT] <= 1'b1;
            end
        end
    end
    // Flash command register, kept for software.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            fcmd_q <= 8'h00;
        end else if (wr && addr == `ADDR_FCMD) begin
            fcmd_q <= wdata;
        end
    end
    // Protect byte image, all ones after reset.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prot_q <= `PROT_RESET;
        end else if (wr && addr == `ADDR_PROT) begin
            prot_q <= wdata;
        end
    end
    // Decode protection; only all-ones in the low four bits is a legal open setting here.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            block_wen_q <= 16'h0000;
            prot_bad_q <= 1'b0;
        end else if (prot_q[3:0] == `PROT_ALL_OPEN) begin
            block_wen_q <= self_prog_q ? 16'hFFFF : 16'h0000;
            prot_bad_q <= 1'b0;
        end else begin
            block_wen_q <= 16'h0000;
            prot_bad_q <= 1'b1;
        end
    end
    // Read port, data stand one cycle after the strobe.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata_q <= 8'h00;
        end else if (rd) begin
            case (addr)
                `ADDR_KEY: rdata_q <= 8'h00;
                `ADDR_MODE: rdata_q <= mode_q;
                `ADDR_STATUS: rdata_q <= status_q;
                `ADDR_FCMD: rdata_q <= fcmd_q;
                `ADDR_PROT: rdata_q <= prot_q;
                `ADDR_IRQ_STAT: rdata_q <= {6'h00, irq_stat};
                `ADDR_IRQ_MASK: rdata_q <= {6'h00, irq_mask};
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    // A failure leaves the mode unchanged for the next cycle.
    fail_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        fail |=> $stable(mode_q))
        else $error("mode changed on failed sequence");
    // Failure raises the error flag the cycle after.
    fail_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
        fail |=> status_q[0])
        else $error("error flag not set");
    // Key, value, inverse, value back to back enters self programming.
    entry_seq_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_key && wdata == 8'hA5 && u_seq.state_q == SEQ_IDLE)
        ##1 (wr_mode && wdata == 8'h01) ##1 (wr_mode && wdata == 8'hFE)
        ##1 (wr_mode && wdata == 8'h01) |=> ##1 self_prog_q)
        else $error("valid entry did not set mode");
    // Mode register does not change on the arming mode write.
    arm_noapply_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_mode && u_seq.state_q == SEQ_KEYED) |=> ##1 $stable(mode_q))
        else $error("arming write applied");
    // Open protect byte in self programming enables all blocks.
    prot_open_a: assert property (@(posedge clk) disable iff (!reset_n)
        (prot_q == 8'hFF && self_prog_q) |=> block_wen_q == 16'hFFFF)
        else $error("open protect byte did not enable blocks");
endmodule

// [rtl/selfprog_pkg.sv]
// Types shared by the mode entry guard files.
package selfprog_pkg;
    // Progress of the guarded write sequence.
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_KEYED,
        SEQ_ARMED,
        SEQ_INVERTED
    } seq_state_e;
    // One register byte.
    typedef logic [7:0] byte_t;
endpackage

// [rtl/unlock_seq.sv]
// Sequence checker for the guarded mode control write.
`timescale 1ns/1ns
`include "selfprog_cfg.svh"
module unlock_seq (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wr_key, // Write to the protect key register.
    input wire logic wr_mode, // Write to the mode control register.
    input wire logic wr_other, // Write to any other register.
    input wire logic [7:0] wdata,
    output logic apply, // One-cycle pulse: third write accepted.
    output logic fail // One-cycle pulse: sequence broken.
);
    import selfprog_pkg::*;
    seq_state_e state_q; // Current step of the sequence.
    byte_t target_q; // Value captured by the arming write.
    // Step through key, value, inverse, value; any other write breaks it.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= SEQ_IDLE;
            target_q <= 8'h00;
            apply <= 1'b0;
            fail <= 1'b0;
        end else begin
            apply <= 1'b0;
            fail <= 1'b0;
            case (state_q)
                SEQ_IDLE: begin
                    if (wr_key && wdata == `KEY_VALUE) begin
                        state_q <= SEQ_KEYED;
                    end else if (wr_mode) begin
                        fail <= 1'b1;
                    end
                end
                SEQ_KEYED: begin
                    if (wr_mode) begin
                        target_q <= wdata;
                        state_q <= SEQ_ARMED;
                    end else if (wr_key || wr_other) begin
                        fail <= 1'b1;
                        state_q <= SEQ_IDLE;
                    end
                end
                SEQ_ARMED: begin
                    if (wr_mode && wdata == ~target_q) begin
                        state_q <= SEQ_INVERTED;
                    end else if (wr_mode || wr_key || wr_other) begin
                        fail <= 1'b1;
                        state_q <= SEQ_IDLE;
                    end
                end
                SEQ_INVERTED: begin
                    if (wr_mode && wdata == target_q) begin
                        apply <= 1'b1;
                        state_q <= SEQ_IDLE;
                    end else if (wr_mode || wr_key || wr_other) begin
                        fail <= 1'b1;
                        state_q <= SEQ_IDLE;
                    end
                end
                default: state_q <= SEQ_IDLE;
            endcase
        end
    end
    // A mode write without a preceding key must fail next cycle.
    nokey_fail_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == SEQ_IDLE && wr_mode) |=> fail)
        else $error("mode write without key did not fail");
    // Apply and fail never pulse together.
    apply_excl_a: assert property (@(posedge clk) disable iff (!reset_n)
        !(apply && fail))
        else $error("apply and fail at once");
    // Apply only follows a matching write in the inverted step.
    apply_cause_a: assert property (@(posedge clk) disable iff (!reset_n)
        apply |-> $past(state_q) == SEQ_INVERTED && $past(wr_mode))
        else $error("apply without third write");
endmodule
